/* ioc_osc_ctrl.v */
/*
 * oscillator control: internal oscillator enable, ready, calibration and
 * output divider; external oscillator mode, pin takeover, crystal valid
 * and the divided-by-eight peripheral clock; sources for the system clock.
 * assumes an AHB-Lite master with one slave, and an analog block that
 * reports internal ready, crystal amplitude valid and the external clock.
 */
`timescale 1ns/100ps
`default_nettype none
`include "ioc_defines.vh"

module ioc_osc_ctrl (
    // clock and reset
    input wire clk,
    input wire resetn,
    // ahb-lite slave
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output wire hreadyout,
    output wire hresp,
    output reg [31:0] hrdata,
    // analog oscillator status, asynchronous
    input wire int_osc_ready_in,
    input wire crystal_amp_ok_in,
    input wire ext_osc_clk_in,
    // analog oscillator controls
    output wire internal_osc_enable,
    output wire [7:0] internal_osc_calibration,
    output wire external_osc_drive_en,
    output wire [2:0] external_osc_mode,
    output wire [2:0] external_freq_range,
    // port pin takeover
    output wire port0_pin2_osc,
    output wire port0_pin3_osc,
    // clock selection and derived clocks
    output wire system_clock_sel_ext,
    output reg int_div_tick,
    output wire ext_div8_tick,
    output wire ext_div8_clk,
    // interrupt
    output wire irq
);

    // ==========================================================
    // mode decode helpers

    // any mode other than 00x runs the drive circuit
    function xm_on;
        input [2:0] m;
        begin
            xm_on = m[2] | m[1];
        end
    endfunction

    // crystal or resonator modes use both pins
    function xm_xtal;
        input [2:0] m;
        begin
            xm_xtal = (m == `IOC_XM_XTAL) || (m == `IOC_XM_XTAL_HALF);
        end
    endfunction

    // modes with an extra divide by two stage
    function xm_half;
        input [2:0] m;
        begin
            xm_half = (m == `IOC_XM_CMOS_HALF) || (m == `IOC_XM_XTAL_HALF);
        end
    endfunction

    // last count of the internal divider for a divide code
    function [2:0] div_last;
        input [1:0] sel;
        begin
            div_last = 3'h7 >> sel;
        end
    endfunction

    // ==========================================================
    // register state

    reg icen_reg;
    reg [1:0] idiv_reg;
    reg [7:0] ical_reg;
    reg [2:0] xmode_reg;
    reg [2:0] xfr_reg;
    reg csel_reg;
    reg [`IOC_EV_N-1:0] stat_reg;
    reg [`IOC_EV_N-1:0] stat_next;
    reg [`IOC_EV_N-1:0] mask_reg;

    // ==========================================================
    // bus phase tracking

    reg wr_pend_reg;
    reg rd_pend_reg;
    reg [7:0] idx_reg;
    reg hit_reg;
    wire take;
    wire idx_hit;
    wire wr_go;

    // ==========================================================
    // synchronised analog status

    wire [2:0] stat_sync;
    wire irdy_s;
    wire xamp_s;
    wire xclk_s;
    reg irdy_prev_reg;
    reg xvld_prev_reg;
    wire irdy_flag;
    wire xvld_flag;
    wire [`IOC_EV_N-1:0] ev;

    // ==========================================================
    // internal divider state

    reg [2:0] idiv_cnt_reg;

    // ready reset value is one so the flag reads set out of reset
    ioc_sync2 #(
        .W(3),
        .RST_VAL({1'b0, 1'b0, `IOC_RDY_RST})
    ) u_sync (
        .clk(clk),
        .resetn(resetn),
        .d_async({ext_osc_clk_in, crystal_amp_ok_in, int_osc_ready_in}),
        .q_sync(stat_sync)
    );

    assign irdy_s = stat_sync[0];
    assign xamp_s = stat_sync[1];
    assign xclk_s = stat_sync[2];

    // ==========================================================
    // status flags seen by software

    // ready only while enabled and running
    assign irdy_flag = icen_reg & irdy_s;
    // crystal valid means nothing outside crystal modes
    assign xvld_flag = xm_xtal(xmode_reg) & xamp_s;

    // ==========================================================
    // ahb-lite slave: zero wait writes, one wait read

    // a transfer is taken only while the bus is ready
    assign take = hsel & htrans[1] & hready;
    assign idx_hit = (haddr[31:`IOC_HI_LSB] == 22'h00_0000) &&
                     ((haddr[`IOC_IDX_MSB:`IOC_IDX_LSB] == `IOC_IDX_XCTL) ||
                      (haddr[`IOC_IDX_MSB:`IOC_IDX_LSB] == `IOC_IDX_ICTL) ||
                      (haddr[`IOC_IDX_MSB:`IOC_IDX_LSB] == `IOC_IDX_ICAL) ||
                      (haddr[`IOC_IDX_MSB:`IOC_IDX_LSB] == `IOC_IDX_CSEL) ||
                      (haddr[`IOC_IDX_MSB:`IOC_IDX_LSB] == `IOC_IDX_STAT) ||
                      (haddr[`IOC_IDX_MSB:`IOC_IDX_LSB] == `IOC_IDX_MASK));
    assign wr_go = wr_pend_reg & hit_reg;
    // the read wait state lets a preceding write settle before sampling
    assign hreadyout = ~rd_pend_reg;
    assign hresp = 1'b0;

    // address phase capture
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wr_pend_reg <= 1'b0;
            rd_pend_reg <= 1'b0;
            idx_reg <= 8'h00;
            hit_reg <= 1'b0;
        end else begin
            if (hready) begin
                wr_pend_reg <= take & hwrite;
                rd_pend_reg <= take & ~hwrite;
                hit_reg <= take & idx_hit;
                if (take) begin
                    idx_reg <= haddr[`IOC_IDX_MSB:`IOC_IDX_LSB];
                end
            end else begin
                rd_pend_reg <= 1'b0;
            end
        end
    end

    // read data loads during the wait state; unmapped reads give zero
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            hrdata <= 32'h0000_0000;
        end else if (rd_pend_reg) begin
            hrdata <= 32'h0000_0000;
            if (hit_reg) begin
                case (idx_reg)
                    `IOC_IDX_ICTL: begin
                        hrdata[`IOC_ICTL_EN] <= icen_reg;
                        hrdata[`IOC_ICTL_RDY] <= irdy_flag;
                        hrdata[`IOC_ICTL_DIV_MSB:`IOC_ICTL_DIV_LSB] <= idiv_reg;
                    end
                    `IOC_IDX_XCTL: begin
                        hrdata[`IOC_XCTL_VLD] <= xvld_flag;
                        hrdata[`IOC_XCTL_MODE_MSB:`IOC_XCTL_MODE_LSB] <= xmode_reg;
                        hrdata[`IOC_XCTL_FR_MSB:`IOC_XCTL_FR_LSB] <= xfr_reg;
                    end
                    `IOC_IDX_ICAL: begin
                        hrdata[7:0] <= ical_reg;
                    end
                    `IOC_IDX_CSEL: begin
                        hrdata[`IOC_CSEL_EXT] <= csel_reg;
                    end
                    `IOC_IDX_STAT: begin
                        hrdata[`IOC_EV_N-1:0] <= stat_reg;
                    end
                    `IOC_IDX_MASK: begin
                        hrdata[`IOC_EV_N-1:0] <= mask_reg;
                    end
                    default: begin
                        hrdata <= 32'h0000_0000;
                    end
                endcase
            end
        end
    end

    // ==========================================================
    // control register writes

    // register writes land at the end of the data phase
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            icen_reg <= `IOC_EN_RST;
            idiv_reg <= `IOC_DIV_RST;
            ical_reg <= `IOC_CAL_RST;
            xmode_reg <= `IOC_XM_RST;
            xfr_reg <= `IOC_FR_RST;
            csel_reg <= `IOC_CSEL_RST;
            mask_reg <= `IOC_EV_RST;
        end else if (wr_go) begin
            case (idx_reg)
                `IOC_IDX_ICTL: begin
                    icen_reg <= hwdata[`IOC_ICTL_EN];
                    idiv_reg <= hwdata[`IOC_ICTL_DIV_MSB:`IOC_ICTL_DIV_LSB];
                end
                `IOC_IDX_XCTL: begin
                    xmode_reg <= hwdata[`IOC_XCTL_MODE_MSB:`IOC_XCTL_MODE_LSB];
                    xfr_reg <= hwdata[`IOC_XCTL_FR_MSB:`IOC_XCTL_FR_LSB];
                end
                `IOC_IDX_ICAL: begin
                    ical_reg <= hwdata[7:0];
                end
                `IOC_IDX_CSEL: begin
                    // switching is software's call once valid
                    csel_reg <= hwdata[`IOC_CSEL_EXT];
                end
                `IOC_IDX_MASK: begin
                    mask_reg <= hwdata[`IOC_EV_N-1:0];
                end
                default: begin
                    mask_reg <= mask_reg;
                end
            endcase
        end
    end

    // ==========================================================
    // events and interrupt

    // edges of the two readiness flags
    assign ev[`IOC_EV_XVLD] = xvld_flag & ~xvld_prev_reg;
    assign ev[`IOC_EV_IRDY] = irdy_flag & ~irdy_prev_reg;
    assign ev[`IOC_EV_ILOST] = ~irdy_flag & irdy_prev_reg;

    // write one to clear; a new event in the same cycle wins
    always @* begin
        stat_next = stat_reg;
        if (wr_go && (idx_reg == `IOC_IDX_STAT)) begin
            stat_next = stat_reg & ~hwdata[`IOC_EV_N-1:0];
        end
        stat_next = stat_next | ev;
    end

    // previous flags start at reset values, so no event fires at release
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            stat_reg <= `IOC_EV_RST;
            irdy_prev_reg <= `IOC_RDY_RST;
            xvld_prev_reg <= 1'b0;
        end else begin
            stat_reg <= stat_next;
            irdy_prev_reg <= irdy_flag;
            xvld_prev_reg <= xvld_flag;
        end
    end

    assign irq = |(stat_reg & mask_reg);

    // ==========================================================
    // internal clock divider

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            idiv_cnt_reg <= 3'h0;
            int_div_tick <= 1'b0;
        end else if (!icen_reg) begin
            // a stopped oscillator gives no strobes
            idiv_cnt_reg <= 3'h0;
            int_div_tick <= 1'b0;
        end else if (idiv_cnt_reg >= div_last(idiv_reg)) begin
            idiv_cnt_reg <= 3'h0;
            int_div_tick <= 1'b1;
        end else begin
            idiv_cnt_reg <= idiv_cnt_reg + 3'h1;
            int_div_tick <= 1'b0;
        end
    end

    // ==========================================================
    // analog controls and pin takeover

    assign internal_osc_enable = icen_reg;
    assign internal_osc_calibration = ical_reg;
    assign external_osc_drive_en = xm_on(xmode_reg);
    assign external_osc_mode = xmode_reg;
    // range setting sets RC bias current
    assign external_freq_range = xfr_reg;
    assign port0_pin2_osc = xm_xtal(xmode_reg);
    assign port0_pin3_osc = xm_on(xmode_reg);
    // external only after software selects it
    assign system_clock_sel_ext = csel_reg;

    // ==========================================================
    // external divided clock for timers and counter array

    ioc_ext_div8 u_xdiv (
        .clk(clk),
        .resetn(resetn),
        .run(xm_on(xmode_reg)),
        .half(xm_half(xmode_reg)),
        .ext_sync(xclk_s),
        .tick(ext_div8_tick),
        .div_clk(ext_div8_clk)
    );

endmodule
`default_nettype wire

/* ioc_defines.vh */
/*
 * shared constants of the oscillator control block: register indices,
 * field positions, reset values and mode codes.
 * assumes it is included by bare name from every design file that needs it.
 */
`ifndef IOC_DEFINES_VH
`define IOC_DEFINES_VH

// ==========================================================
// register indices (byte address is four times the index)
`define IOC_IDX_XCTL 8'hb1
`define IOC_IDX_ICTL 8'hb2
`define IOC_IDX_ICAL 8'hc0
`define IOC_IDX_CSEL 8'hc1
`define IOC_IDX_STAT 8'hc2
`define IOC_IDX_MASK 8'hc3

// ==========================================================
// address decode positions
`define IOC_IDX_LSB 2
`define IOC_IDX_MSB 9
`define IOC_HI_LSB 10

// ==========================================================
// internal oscillator control fields
`define IOC_ICTL_EN 7
`define IOC_ICTL_RDY 6
`define IOC_ICTL_DIV_MSB 1
`define IOC_ICTL_DIV_LSB 0
`define IOC_DIV_RST 2'h0
`define IOC_EN_RST 1'b1
`define IOC_RDY_RST 1'b1

// ==========================================================
// external oscillator control fields
`define IOC_XCTL_VLD 7
`define IOC_XCTL_MODE_MSB 6
`define IOC_XCTL_MODE_LSB 4
`define IOC_XCTL_FR_MSB 2
`define IOC_XCTL_FR_LSB 0
`define IOC_XM_RST 3'h0
`define IOC_FR_RST 3'h0
`define IOC_XM_CMOS 3'h2
`define IOC_XM_CMOS_HALF 3'h3
`define IOC_XM_RC 3'h4
`define IOC_XM_CAP 3'h5
`define IOC_XM_XTAL 3'h6
`define IOC_XM_XTAL_HALF 3'h7

// ==========================================================
// calibration, clock select and interrupt registers
`define IOC_CAL_RST 8'h40
`define IOC_CSEL_EXT 0
`define IOC_CSEL_RST 1'b0
`define IOC_EV_N 3
`define IOC_EV_XVLD 0
`define IOC_EV_IRDY 1
`define IOC_EV_ILOST 2
`define IOC_EV_RST 3'h0

// ==========================================================
// external divide counts (edges minus one before a tick)
`define IOC_XDIV_LAST 4'h7
`define IOC_XDIV_HALF_LAST 4'hf

`endif

/* ioc_sync2.v */
/*
 * two flip-flop synchroniser for a bundle of levels.
 * assumes each bit is a slow level from outside the clk domain.
 */
`timescale 1ns/100ps
`default_nettype none

module ioc_sync2 #(
    parameter W = 1,
    parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
    // clock and reset
    input wire clk,
    input wire resetn,
    // levels
    input wire [W-1:0] d_async,
    output reg [W-1:0] q_sync
);

    reg [W-1:0] meta_reg;

    // first stage feeds only the second stage
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            meta_reg <= RST_VAL;
            q_sync <= RST_VAL;
        end else begin
            meta_reg <= d_async;
            q_sync <= meta_reg;
        end
    end

endmodule
`default_nettype wire

/* ioc_ext_div8.v */
/*
 * external oscillator divided by eight, retimed to the system clock.
 * assumes ext_sync is already synchronised and that the external clock
 * runs no faster than half of clk, so every level is seen by at least one sample.
 */
`timescale 1ns/100ps
`default_nettype none
`include "ioc_defines.vh"

module ioc_ext_div8 (
    // clock and reset
    input wire clk,
    input wire resetn,
    // control
    input wire run,
    input wire half,
    input wire ext_sync,
    // retimed peripheral clock
    output reg tick,
    output reg div_clk
);

    reg prev_reg;
    reg [3:0] cnt_reg;
    wire rise;
    wire [3:0] last;

    assign rise = ext_sync & ~prev_reg;
    // halved modes take twice the edges per output period
    assign last = half ? `IOC_XDIV_HALF_LAST : `IOC_XDIV_LAST;

    // edge counter; every tick lands on a clk edge, so jitter is one cycle
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            prev_reg <= 1'b0;
            cnt_reg <= 4'h0;
            tick <= 1'b0;
            div_clk <= 1'b0;
        end else begin
            prev_reg <= ext_sync;
            tick <= 1'b0;
            if (!run) begin
                cnt_reg <= 4'h0;
                div_clk <= 1'b0;
            end else if (rise) begin
                if (cnt_reg >= last) begin
                    cnt_reg <= 4'h0;
                    tick <= 1'b1;
                end else begin
                    cnt_reg <= cnt_reg + 4'h1;
                end
                div_clk <= (cnt_reg >= (last >> 1)) && (cnt_reg != last);
            end
        end
    end

endmodule
`default_nettype wire

/* ioc_osc_ctrl_chk.sv */
/* checker: bus timing, pin takeover, reset values, derived pulses.
   assumes it is bound to ioc_osc_ctrl and sees its ports only. */
`timescale 1ns/100ps
`default_nettype none
module ioc_osc_ctrl_chk (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // bus
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    // oscillator side
    input wire logic internal_osc_enable,
    input wire logic [7:0] internal_osc_calibration,
    input wire logic external_osc_drive_en,
    input wire logic [2:0] external_osc_mode,
    input wire logic port0_pin2_osc,
    input wire logic port0_pin3_osc,
    input wire logic system_clock_sel_ext,
    input wire logic int_div_tick,
    input wire logic ext_div8_tick
);
    // ==========
    // one clock domain
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    // a transfer is taken at this edge
    wire logic take;
    assign take = hsel && htrans[1] && hready;
    reset_vals_a: assert property ($rose(resetn) |->
        !system_clock_sel_ext && internal_osc_enable && internal_osc_calibration == 8'h40)
        else $error("values after reset wrong");
    // one wait state on reads only, never an error
    read_wait_a: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
    write_fast_a: assert property (take && hwrite |=> hreadyout)
        else $error("write stalled");
    resp_okay_a: assert property (hresp == 1'b0)
        else $error("error response");
    pin2_take_a: assert property (port0_pin2_osc == (external_osc_mode[2:1] == 2'b11))
        else $error("pin2 takeover wrong");
    pin3_take_a: assert property (port0_pin3_osc == (external_osc_mode[2:1] != 2'b00))
        else $error("pin3 takeover wrong");
    drive_mode_a: assert property (external_osc_drive_en == (external_osc_mode[2:1] != 2'b00))
        else $error("drive enable wrong");
    // divided clocks quiet when off, external ticks spaced when on
    int_tick_off_a: assert property (!internal_osc_enable [*2] |-> !int_div_tick)
        else $error("tick while disabled");
    ext_tick_off_a: assert property ((external_osc_mode[2:1] == 2'b00) [*6] |-> !ext_div8_tick)
        else $error("external tick while off");
    ext_tick_gap_a: assert property (ext_div8_tick |=> !ext_div8_tick [*8])
        else $error("external ticks too close");
    // main scenarios reached
    cover property (take && !hwrite);
    cover property (port0_pin2_osc);
    cover property (ext_div8_tick);
endmodule
bind ioc_osc_ctrl ioc_osc_ctrl_chk u_chk (.clk(clk), .resetn(resetn), .hsel(hsel), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .internal_osc_enable(internal_osc_enable), .internal_osc_calibration(internal_osc_calibration),
    .external_osc_drive_en(external_osc_drive_en), .external_osc_mode(external_osc_mode),
    .port0_pin2_osc(port0_pin2_osc), .port0_pin3_osc(port0_pin3_osc),
    .system_clock_sel_ext(system_clock_sel_ext), .int_div_tick(int_div_tick),
    .ext_div8_tick(ext_div8_tick));
`default_nettype wire

/* ioc_osc_model.sv */
/* behavioural oscillators at the far side: internal ready, crystal
   amplitude detector and an external clock.
   assumes the block's enable and mode outputs drive it directly. */
`timescale 1ns/100ps
`default_nettype none
module ioc_osc_model #(
    parameter real RDY_NS = 200.0,
    parameter real XTAL_NS = 2000.0,
    parameter real EXT_HALF_NS = 21.0
) (
    // controls from the block
    input wire logic internal_osc_enable,
    input wire logic external_osc_drive_en,
    input wire logic [2:0] external_osc_mode,
    // analog status and clock
    output logic int_osc_ready_in,
    output logic crystal_amp_ok_in,
    output logic ext_osc_clk_in
);
    initial begin
        int_osc_ready_in = 1'b1;
        crystal_amp_ok_in = 1'b0;
        ext_osc_clk_in = 1'b0;
    end
    // ready drops at once, returns only after settling
    always @(negedge internal_osc_enable) int_osc_ready_in = 1'b0;
    always begin
        @(posedge internal_osc_enable);
        #(RDY_NS);
        int_osc_ready_in = internal_osc_enable;
    end
    // amplitude detector needs a settling span in crystal modes
    always begin
        wait (external_osc_mode[2:1] == 2'b11);
        #(XTAL_NS);
        crystal_amp_ok_in = (external_osc_mode[2:1] == 2'b11);
        wait (external_osc_mode[2:1] != 2'b11);
        crystal_amp_ok_in = 1'b0;
    end
    // digital level, slower than the system clock, still when not driven
    always begin
        if (external_osc_drive_en === 1'b1) begin
            #(EXT_HALF_NS);
            ext_osc_clk_in = ~ext_osc_clk_in;
        end else begin
            ext_osc_clk_in = 1'b0;
            @(external_osc_drive_en);
        end
    end
endmodule
`default_nettype wire

/* ioc_osc_ctrl_test.sv */
/* testbench of the oscillator control block over AHB-Lite.
   assumes the design files, the checker and the oscillator model. */
`timescale 1ns/100ps
`default_nettype none
`include "ioc_defines.vh"
module ioc_osc_ctrl_test;
    // ==========
    // signals
    logic clk, resetn, hsel, hwrite;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, rd, k;
    wire logic hreadyout, hresp, irq, ien, xen, p2, p3, sel_ext, itick, xtick, rdy, amp, xclk, dclk;
    wire logic [31:0] hrdata;
    wire logic [7:0] cal;
    wire logic [2:0] xmode, xrange;
    int n, num_errors, checked;
    localparam logic [31:0] A_X = {22'h00_0000, `IOC_IDX_XCTL, 2'b00};
    localparam logic [31:0] A_I = {22'h00_0000, `IOC_IDX_ICTL, 2'b00};
    localparam logic [31:0] A_C = {22'h00_0000, `IOC_IDX_ICAL, 2'b00};
    localparam logic [31:0] A_S = {22'h00_0000, `IOC_IDX_CSEL, 2'b00};
    localparam logic [31:0] A_ST = {22'h00_0000, `IOC_IDX_STAT, 2'b00};
    localparam logic [31:0] A_M = {22'h00_0000, `IOC_IDX_MASK, 2'b00};
    ioc_osc_ctrl DUT (.clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .int_osc_ready_in(rdy), .crystal_amp_ok_in(amp),
        .ext_osc_clk_in(xclk), .internal_osc_enable(ien), .internal_osc_calibration(cal),
        .external_osc_drive_en(xen), .external_osc_mode(xmode), .external_freq_range(xrange),
        .port0_pin2_osc(p2), .port0_pin3_osc(p3), .system_clock_sel_ext(sel_ext),
        .int_div_tick(itick), .ext_div8_tick(xtick), .ext_div8_clk(dclk), .irq(irq));
    ioc_osc_model osc (.internal_osc_enable(ien), .external_osc_drive_en(xen),
        .external_osc_mode(xmode), .int_osc_ready_in(rdy), .crystal_amp_ok_in(amp), .ext_osc_clk_in(xclk));
    always #2 clk = ~clk;
    // ==========
    // tasks
    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus_wait;
        do @(posedge clk); while (hreadyout !== 1'b1);
    endtask
    // address phase, then data phase; read data taken at its last edge
    task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'b10;
        bus_wait();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        bus_wait();
        rd = hrdata;
    endtask
    task automatic rc(input logic [31:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0000_0000);
        check_word(rd, exp);
    endtask
    // cycles between two pulses of the chosen tick
    task automatic gap(input logic ext, output int cyc);
        int w;
        w = 0;
        while ((ext ? xtick : itick) !== 1'b1 && w < 400) begin
            @(posedge clk);
            w++;
        end
        @(posedge clk);
        cyc = 1;
        while ((ext ? xtick : itick) !== 1'b1 && cyc < 400) begin
            @(posedge clk);
            cyc++;
        end
    endtask
    task automatic stop_test;
        $display("checked %0d, num_errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // a hang ends the run well past the expected few thousand cycles
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        stop_test();
    end
    // ==========
    // tests
    initial begin
        clk = 0;
        resetn = 0;
        hsel = 0;
        hwrite = 0;
        htrans = 2'b00;
        hsize = 3'b010;
        haddr = 0;
        hwdata = 0;
        num_errors = 0;
        checked = 0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        check_word(sel_ext, 1'b0);
        rc(A_I, 32'h0000_00c0);
        rc(A_C, 32'h0000_0040);
        rc(A_X, 32'h0000_0000);
        rc(A_S, 32'h0000_0000);
        rc(A_M, 32'h0000_0000);
        xfer(1'b1, 32'h0000_02c0, 32'hffff_ffff);
        rc(32'h0000_02c0, 32'h0000_0000);
        rc(32'h0000_0400, 32'h0000_0000);
        gap(1'b0, n);
        gap(1'b0, n);
        check_word(n, 32'h0000_0008);
        $display("test reset done");
        for (k = 0; k < 4; k++) begin
            xfer(1'b1, A_I, 32'h0000_0080 | k);
            rc(A_I, 32'h0000_00c0 | k);
            gap(1'b0, n);
            gap(1'b0, n);
            check_word(n, 32'h0000_0008 >> k);
        end
        $display("test divider done");
        xfer(1'b1, A_I, 32'h0000_003c);
        repeat (4) @(posedge clk);
        rc(A_I, 32'h0000_0000);
        check_word(ien, 1'b0);
        rc(A_ST, 32'h0000_0004);
        xfer(1'b1, A_I, 32'h0000_0080);
        repeat (60) @(posedge clk);
        rc(A_I, 32'h0000_00c0);
        rc(A_ST, 32'h0000_0006);
        check_word(irq, 1'b0);
        xfer(1'b1, A_M, 32'h0000_0002);
        repeat (2) @(posedge clk);
        check_word(irq, 1'b1);
        xfer(1'b1, A_ST, 32'h0000_0002);
        repeat (2) @(posedge clk);
        check_word(irq, 1'b0);
        rc(A_ST, 32'h0000_0004);
        xfer(1'b1, A_ST, 32'h0000_0004);
        rc(A_ST, 32'h0000_0000);
        $display("test enable done");
        for (k = 0; k < 8; k++) begin
            xfer(1'b1, A_X, (k << 4) | 32'h0000_0008 | k);
            rc(A_X, (k << 4) | k);
            check_word(p2, k >= 6);
            check_word(p3, k >= 2);
            check_word(xen, k >= 2);
            check_word(xrange, k[2:0]);
        end
        $display("test modes done");
        xfer(1'b1, A_M, 32'h0000_0001);
        // mode and crystal range set first
        xfer(1'b1, A_X, 32'h0000_0067);
        repeat (600) @(posedge clk);
        // poll the valid flag, then switch
        rd = 0;
        for (k = 0; k < 100 && rd[7] !== 1'b1; k++) xfer(1'b0, A_X, 32'h0000_0000);
        check_word(rd, 32'h0000_00e7);
        check_word(irq, 1'b1);
        rc(A_ST, 32'h0000_0001);
        xfer(1'b1, A_S, 32'h0000_0001);
        rc(A_S, 32'h0000_0001);
        check_word(sel_ext, 1'b1);
        xfer(1'b1, A_ST, 32'h0000_0001);
        repeat (2) @(posedge clk);
        check_word(irq, 1'b0);
        xfer(1'b1, A_S, 32'h0000_0000);
        $display("test crystal done");
        xfer(1'b1, A_X, 32'h0000_0020);
        gap(1'b1, n);
        gap(1'b1, n);
        check_word(n >= 83 && n <= 85, 1'b1);
        check_word(dclk, 1'b0);
        repeat (60) @(posedge clk);
        check_word(dclk, 1'b1);
        xfer(1'b1, A_X, 32'h0000_0030);
        gap(1'b1, n);
        gap(1'b1, n);
        check_word(n >= 167 && n <= 169, 1'b1);
        xfer(1'b1, A_X, 32'h0000_0000);
        $display("test divided clock done");
        stop_test();
    end
endmodule
`default_nettype wire
